// File: design/wtb_map.vh
// constants for the watchdog and time base block
`ifndef WTB_MAP_VH
`define WTB_MAP_VH

// shared chain: 8-stage divider then 7-bit prescaler
`define WTB_DIV_STAGES   8
`define WTB_PRE_BITS     7
`define WTB_CHAIN_W      15
`define WTB_CHAIN_RST    15'h0000

// instruction clock is system clock over four
`define WTB_IDIV_W       2
`define WTB_IDIV_LAST    2'h3

// clock source selection codes
`define WTB_SRC_WDTOSC   2'h0
`define WTB_SRC_INSTR    2'h1
`define WTB_SRC_RTC      2'h2

// time-out exponent bases (selector 0 means 2^12)
`define WTB_TO_BASE      4'hC
// lcd and buzzer tap exponent base (selector 0 means 2^2)
`define WTB_TAP_BASE     4'h2
`define WTB_LCD_MAX      3'h6
`define WTB_BUZ_MAX      3'h7

// time base request flag position and call vector
`define WTB_TBF_BIT      5
`define WTB_TB_VECTOR    8'h14
// fast start-up bit position in the rtc control register
`define WTB_FAST_XTAL_STARTUP_BIT_BIT     4

// reset values of flags and state
`define WTB_FLAG_RST     1'b0
`define WTB_FAST_XTAL_STARTUP_BIT_RST     1'b0

`endif

// File: design/wtb_core.v
// watchdog, shared divider chain, time base, lcd and buzzer taps
`timescale 1ns/1ps
`include "wtb_map.vh"

module wtb_core (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // oscillator ticks, one-cycle pulses
  input  wire       wdt_osc_tick_i,
  input  wire       rtc_osc_tick_i,
  // configuration options
  input  wire       wdt_enable_i,
  input  wire       wdt_osc_enable_i,
  input  wire [1:0] src_sel_i,
  input  wire [1:0] wdt_div_sel_i,
  input  wire [1:0] tb_div_sel_i,
  input  wire [2:0] lcd_div_sel_i,
  input  wire [2:0] buz_div_sel_i,
  input  wire       clear_mode_paired_i,
  input  wire       rtc_is_sys_clk_i,
  // cpu instruction strobes
  input  wire       single_dog_clear_instr_i,
  input  wire       first_half_dog_clear_i,
  input  wire       second_half_dog_clear_i,
  input  wire       sleep_instr_i,
  input  wire       wake_i,
  input  wire       external_reset_pin_n_i,
  // time base interrupt side
  input  wire       tick_irq_enable_i,
  input  wire       stack_full_i,
  input  wire       tick_ack_i,
  input  wire       tick_flag_clr_i,
  // rtc control register bit write
  input  wire       rtc_control_reg_wr_i,
  input  wire [7:0] rtc_control_reg_data_i,
  // status and resets
  output wire       timeout_status_flag_o,
  output wire       powerdown_status_flag_o,
  output wire       full_reset_o,
  output wire       warm_reset_o,
  output wire       sleeping_o,
  // time base request
  output wire       tick_request_flag_o,
  output wire       tick_call_o,
  output wire [7:0] tick_vector_o,
  // clock taps and oscillator control
  output wire       lcd_clk_o,
  output wire       buzzer_clk_o,
  output wire       sys_osc_run_o,
  output wire       fast_xtal_startup_bit_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  reg  [`WTB_IDIV_W-1:0]  idiv_q;
  reg  [`WTB_CHAIN_W-1:0] chain_q;
  reg  [`WTB_CHAIN_W-1:0] chain_d;
  reg                     sleeping_q;
  reg                     to_flag_q;
  reg                     pd_flag_q;
  reg                     first_seen_q;
  reg                     second_seen_q;
  reg                     tick_flag_q;
  reg                     full_rst_q;
  reg                     warm_rst_q;
  reg                     lcd_clk_q;
  reg                     buz_clk_q;
  reg                     fast_xtal_startup_bit_q;
  reg                     src_tick;
  wire                    instr_tick;
  wire [`WTB_CHAIN_W:0]   ones_upto;
  wire                    dog_overflow;
  wire                    tb_overflow;
  wire                    sw_clear;
  wire                    dog_clear;
  wire                    pair_done;
  wire [3:0]              dog_exp;
  wire [3:0]              tb_exp;
  wire [3:0]              lcd_exp;
  wire [3:0]              buz_exp;
  wire                    sleep_now;

  //////////////////////////////////////////////////////////////////////////////
  // instruction clock

  // instr clock frozen with system clock in sleep
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idiv_q <= {`WTB_IDIV_W{1'b0}};
    end else if (!sleeping_q) begin
      idiv_q <= idiv_q + {{(`WTB_IDIV_W-1){1'b0}}, 1'b1};
    end
  end

  // no instruction tick in sleep, so this source gives no watchdog
  // cover there; an oscillator source is the one to pick for that
  assign instr_tick = !sleeping_q && (idiv_q == `WTB_IDIV_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // source selection

  // code 3 picks nothing, so the chain then holds still
  // pick one of three counting sources
  always @* begin
    case (src_sel_i)
      // rc oscillator gated by its enable option
      `WTB_SRC_WDTOSC: src_tick = wdt_osc_tick_i & wdt_osc_enable_i;
      `WTB_SRC_INSTR:  src_tick = instr_tick;
      // 32k oscillator keeps counting in sleep
      `WTB_SRC_RTC:    src_tick = rtc_osc_tick_i;
      default:         src_tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared divider chain

  // a 2^n stage overflows on the tick that finds the low n bits all
  // ones; one and-chain serves the watchdog and the time base alike
  // running and-chain: ones_upto[k] set when low k bits all ones
  assign ones_upto[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < `WTB_CHAIN_W; gi = gi + 1) begin : g_ones
      assign ones_upto[gi+1] = ones_upto[gi] & chain_q[gi];
    end
  endgenerate

  // exponents of the selected divisions
  // lcd codes above 6 would pass 2^8, so they are held at 6;
  // buzzer codes 0..7 map straight onto 2^2..2^9
  assign dog_exp = `WTB_TO_BASE + {2'h0, wdt_div_sel_i};
  assign tb_exp  = `WTB_TO_BASE + {2'h0, tb_div_sel_i};
  assign lcd_exp = `WTB_TAP_BASE
                 + {1'b0, (lcd_div_sel_i > `WTB_LCD_MAX) ? `WTB_LCD_MAX : lcd_div_sel_i};
  assign buz_exp = `WTB_TAP_BASE + {1'b0, buz_div_sel_i};

  // watchdog ends every 2^n source ticks
  // no time-out while the option disables it
  assign dog_overflow = wdt_enable_i && src_tick && ones_upto[dog_exp];
  // time base period 2^n source ticks
  assign tb_overflow  = src_tick && ones_upto[tb_exp];

  assign pair_done = (first_seen_q | first_half_dog_clear_i)
                   & (second_seen_q | second_half_dog_clear_i);
  // clear instructions do nothing when disabled
  assign sw_clear  = wdt_enable_i
                   && (clear_mode_paired_i ? pair_done : single_dog_clear_instr_i);
  // halt ignored while asleep or while the pin holds reset, so the
  // flags follow the sleep state exactly
  assign sleep_now = sleep_instr_i && !sleeping_q && external_reset_pin_n_i;
  // pin, clear instruction or sleep restart count
  assign dog_clear = !external_reset_pin_n_i || sw_clear || sleep_now;

  // 15-bit chain advanced by the source tick
  // a clear wins over a tick in the same cycle
  always @* begin
    chain_d = chain_q;
    if (dog_clear) begin
      chain_d = `WTB_CHAIN_RST;
    end else if (src_tick) begin
      chain_d = chain_q + {{(`WTB_CHAIN_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_q <= `WTB_CHAIN_RST;
    end else begin
      chain_q <= chain_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // paired clear tracking

  // remember halves until the pair completes
  // halves are dropped on leaving paired mode, so a stale first
  // half cannot pair with a second half much later
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (!wdt_enable_i || !clear_mode_paired_i || pair_done) begin
      first_seen_q  <= 1'b0;
      second_seen_q <= 1'b0;
    end else begin
      if (first_half_dog_clear_i) begin
        first_seen_q <= 1'b1;
      end
      if (second_half_dog_clear_i) begin
        second_seen_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep state and reset pulses

  // sleep entered on halt, left on wake, pin or overflow
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleeping_q <= 1'b0;
    end else if (sleeping_q) begin
      if (wake_i || dog_overflow || !external_reset_pin_n_i) begin
        sleeping_q <= 1'b0;
      end
    end else if (sleep_instr_i && external_reset_pin_n_i) begin
      sleeping_q <= 1'b1;
    end
  end

  // one-cycle reset requests toward the core
  // registered so the core sees a clean pulse; sleeping_q at the
  // overflow edge decides between the full and the warm kind
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_rst_q <= 1'b0;
      warm_rst_q <= 1'b0;
    end else begin
      // overflow while running resets the device
      full_rst_q <= dog_overflow && !sleeping_q;
      // overflow in sleep clears only pc and sp
      warm_rst_q <= dog_overflow && sleeping_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags

  // overflow set wins over any clear in the same cycle
  // the pin leaves both flags alone, so software can still tell
  // a pin reset from a time-out afterwards
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_flag_q <= `WTB_FLAG_RST;
      pd_flag_q <= `WTB_FLAG_RST;
    end else begin
      if (dog_overflow) begin
        to_flag_q <= 1'b1;
      end else if (sw_clear || sleep_now) begin
        to_flag_q <= 1'b0;
      end
      // halt sets powerdown, clear instruction drops it
      if (sleep_now) begin
        pd_flag_q <= 1'b1;
      end else if (sw_clear) begin
        pd_flag_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // time base request

  // tick sets request, service or software clears
  // a tick and an ack in one cycle leave the request set
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_flag_q <= `WTB_FLAG_RST;
    end else if (tb_overflow) begin
      tick_flag_q <= 1'b1;
    end else if (tick_ack_i || tick_flag_clr_i) begin
      tick_flag_q <= 1'b0;
    end
  end

  // call to 14H when enabled and stack has room
  assign tick_call_o   = tick_flag_q && tick_irq_enable_i && !stack_full_i;
  assign tick_vector_o = `WTB_TB_VECTOR;

  //////////////////////////////////////////////////////////////////////////////
  // clock taps

  // square wave at source over 2^n is chain bit n-1
  // taps lag the chain by one clock and keep a 50/50 duty; any
  // watchdog clear also restarts their phase
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lcd_clk_q <= 1'b0;
      buz_clk_q <= 1'b0;
    end else begin
      lcd_clk_q <= chain_q[lcd_exp - 4'h1];
      buz_clk_q <= chain_q[buz_exp - 4'h1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rtc fast start-up bit

  // software sets and later clears fast start-up
  // only the fast start-up bit of the written byte is kept here
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_xtal_startup_bit_q <= `WTB_FAST_XTAL_STARTUP_BIT_RST;
    end else if (rtc_control_reg_wr_i) begin
      fast_xtal_startup_bit_q <= rtc_control_reg_data_i[`WTB_FAST_XTAL_STARTUP_BIT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign timeout_status_flag_o   = to_flag_q;
  assign powerdown_status_flag_o = pd_flag_q;
  assign full_reset_o            = full_rst_q;
  assign warm_reset_o            = warm_rst_q;
  assign sleeping_o              = sleeping_q;
  assign tick_request_flag_o     = tick_flag_q;
  assign lcd_clk_o               = lcd_clk_q;
  assign buzzer_clk_o            = buz_clk_q;
  // system osc stops in sleep unless it is the 32k one
  // the 32k one must keep going, as it also feeds the chain
  assign sys_osc_run_o           = !sleeping_q || rtc_is_sys_clk_i;
  assign fast_xtal_startup_bit_o = fast_xtal_startup_bit_q;

endmodule

// File: verification/wtb_core_properties.sv
// port assertions for the watchdog and time base block
`timescale 1ns/1ps
module wtb_core_properties (
  // clock, reset and inputs watched
  input wire       sys_clk_i, rst_n_i, wdt_enable_i, sleep_instr_i, wake_i,
  input wire       external_reset_pin_n_i, tick_irq_enable_i, stack_full_i,
  input wire       rtc_control_reg_wr_i, rtc_is_sys_clk_i,
  input wire [7:0] rtc_control_reg_data_i,
  // outputs watched
  input wire       timeout_status_flag_o, powerdown_status_flag_o, full_reset_o,
  input wire       warm_reset_o, sleeping_o, tick_request_flag_o, tick_call_o,
  input wire       sys_osc_run_o, fast_xtal_startup_bit_o,
  input wire [7:0] tick_vector_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // reset pulses, status flags, sleep entry, time base call, oscillator and start-up bit
  AST_FULL_PULSE: assert property (full_reset_o |-> timeout_status_flag_o ##1 !full_reset_o)
    else $error("full reset without flag or too long");
  AST_WARM_PULSE: assert property (
    warm_reset_o |-> (!sleeping_o && timeout_status_flag_o) ##1 !warm_reset_o)
    else $error("warm reset malformed");
  AST_TO_CAUSE: assert property (
    $rose(timeout_status_flag_o) |-> full_reset_o || warm_reset_o)
    else $error("time-out flag without reset pulse");
  AST_NO_DOG: assert property (
    !wdt_enable_i && !$past(wdt_enable_i) |-> !full_reset_o && !warm_reset_o)
    else $error("reset while watchdog disabled");
  AST_SLEEP: assert property (
    sleep_instr_i && !sleeping_o && !wake_i && external_reset_pin_n_i
    |=> sleeping_o && powerdown_status_flag_o && !timeout_status_flag_o)
    else $error("sleep entry flags wrong");
  AST_CALL: assert property (
    tick_call_o == (tick_request_flag_o && tick_irq_enable_i && !stack_full_i))
    else $error("time base call mismatch");
  AST_VECTOR: assert property (tick_vector_o == 8'h14)
    else $error("wrong call vector");
  AST_OSC: assert property (sleeping_o && !rtc_is_sys_clk_i |-> !sys_osc_run_o)
    else $error("system oscillator runs in sleep");
  AST_FAST_XTAL_STARTUP_BIT: assert property (
    rtc_control_reg_wr_i |=> fast_xtal_startup_bit_o == $past(rtc_control_reg_data_i[4]))
    else $error("fast start-up bit not written");
  COV_FULL: cover property (full_reset_o);
  COV_WARM: cover property (warm_reset_o);
  COV_CALL: cover property (tick_call_o);
endmodule
bind wtb_core wtb_core_properties u_wtb_core_properties (.*);

// File: verification/wtb_cpu_model.sv
// cpu core model: services time base calls and counts resets
`timescale 1ns/1ps
module wtb_cpu_model (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // core side
  input  wire       slow_i,
  input  wire       tick_call_i,
  input  wire       full_reset_i,
  input  wire       warm_reset_i,
  output reg        tick_ack_o,
  output reg  [7:0] n_full_o,
  output reg  [7:0] n_warm_o
);
  reg [1:0] wait_q;
  always @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_ack_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (tick_ack_o) begin
      tick_ack_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (tick_call_i) begin
      if (!slow_i || wait_q == 2'h3) tick_ack_o <= 1'b1;
      else wait_q <= wait_q + 2'h1;
    end
  end
  // count reset pulses seen by the core
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n_full_o <= 8'h00;
      n_warm_o <= 8'h00;
    end else begin
      n_full_o <= n_full_o + {7'h00, full_reset_i};
      n_warm_o <= n_warm_o + {7'h00, warm_reset_i};
    end
  end
endmodule

// File: verification/tb.sv
// testbench for the watchdog and time base block
`timescale 1ns/1ps
module tb;
  reg        sys_clk_i = 1'b0;
  reg        rst_n_i = 1'b0;
  reg        rtc_osc_tick_i = 1'b0;
  reg        wdt_enable_i = 1'b1;
  reg  [1:0] wdt_div_sel_i = 2'h0;
  reg        clear_mode_paired_i = 1'b0;
  reg        tick_irq_enable_i = 1'b0;
  reg        stack_full_i = 1'b0;
  reg  [7:0] rtc_control_reg_data_i = 8'h00;
  reg  [7:0] ins = 8'h00;
  reg        zero = 1'b1;
  int        ticks, ev_t, i, n_fail, n_compared;
  reg        seen, ev_full, ev_warm, ev_to;
  reg        wdt_osc_enable_i = 1'b0, rtc_is_sys_clk_i = 1'b0;
  reg  [1:0] src_sel_i = 2'h2;
  // lcd ratio 2^3 puts a 32k source nearest 4kHz
  reg  [2:0] lcd_div_sel_i = 3'h1;
  reg  [2:0] buz_div_sel_i = 3'h0;
  int        n;
  // rc oscillator modelled by the same pulse train as the 32k one
  wire       wdt_osc_tick_i = rtc_osc_tick_i;
  wire [1:0] tb_div_sel_i = wdt_div_sel_i;
  wire       single_dog_clear_instr_i = ins[0], first_half_dog_clear_i = ins[1];
  wire       second_half_dog_clear_i = ins[2], sleep_instr_i = ins[3], wake_i = ins[4];
  wire       tick_flag_clr_i = ins[5], rtc_control_reg_wr_i = ins[6];
  wire       external_reset_pin_n_i = ~ins[7];
  wire       timeout_status_flag_o, powerdown_status_flag_o, full_reset_o, warm_reset_o;
  wire       sleeping_o, tick_request_flag_o, tick_call_o, lcd_clk_o, buzzer_clk_o;
  wire       sys_osc_run_o, fast_xtal_startup_bit_o, tick_ack_i;
  wire [7:0] tick_vector_o, n_full, n_warm;
  wtb_core u_wtb_core (.*);
  wtb_cpu_model u_wtb_cpu_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .slow_i(1'b1),
    .tick_call_i(tick_call_o), .full_reset_i(full_reset_o), .warm_reset_i(warm_reset_o),
    .tick_ack_o(tick_ack_i), .n_full_o(n_full), .n_warm_o(n_warm));
  always #10 sys_clk_i = ~sys_clk_i;
  // source tick every other cycle, and a count of them since the last clear
  always @(negedge sys_clk_i) rtc_osc_tick_i <= ~rtc_osc_tick_i;
  always @(posedge sys_clk_i) ticks <= zero ? 0 : ticks + rtc_osc_tick_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task go(input logic [7:0] v, input logic z);
    @(negedge sys_clk_i);
    ins = v;
    zero = z;
    @(negedge sys_clk_i);
    ins = 8'h00;
    zero = 1'b0;
  endtask
  task wait_ev(input int lim);
    seen = 0;
    for (i = 0; i < lim && !seen; i++) begin
      @(negedge sys_clk_i);
      seen = full_reset_o | warm_reset_o;
      {ev_t, ev_full, ev_warm, ev_to} = {ticks, full_reset_o, warm_reset_o, timeout_status_flag_o};
    end
  endtask
  // cycles between two edges of the lcd or buzzer tap, 0 if it stands still
  task half_period(input logic use_buz, output int len);
    logic v0;
    @(negedge sys_clk_i);
    v0 = use_buz ? buzzer_clk_o : lcd_clk_o;
    for (len = 0; len < 1100 && (use_buz ? buzzer_clk_o : lcd_clk_o) === v0; len++)
      @(negedge sys_clk_i);
    v0 = ~v0;
    for (len = 0; len < 1100 && (use_buz ? buzzer_clk_o : lcd_clk_o) === v0; len++)
      @(negedge sys_clk_i);
  endtask
  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1_900_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    zero = 1'b0;
    wait_ev(10000);
    chk({ev_full, ev_to, tick_request_flag_o}, 3'h7);
    chk(ev_t[15:0], 16'h1000);
    wdt_div_sel_i = 2'h1;
    go(8'h01, 1'b1);
    chk({timeout_status_flag_o, powerdown_status_flag_o}, 2'h0);
    wait_ev(20000);
    chk(ev_t[15:0], 16'h2000);
    $display("test time-out done");
    {wdt_div_sel_i, clear_mode_paired_i} = 3'h1;
    go(8'h06, 1'b1);
    repeat (2000) @(negedge sys_clk_i);
    go(8'h01, 1'b0);
    go(8'h02, 1'b0);
    wait_ev(10000);
    chk(ev_t[15:0], 16'h1000);
    go(8'h02, 1'b0);
    repeat (100) @(negedge sys_clk_i);
    go(8'h04, 1'b1);
    wait_ev(10000);
    chk(ev_t[15:0], 16'h1000);
    $display("test paired clear done");
    clear_mode_paired_i = 1'b0;
    go(8'h08, 1'b1);
    chk({sleeping_o, powerdown_status_flag_o, timeout_status_flag_o, sys_osc_run_o}, 4'hC);
    wait_ev(10000);
    chk({ev_warm, ev_full, ev_to, ev_t[15:0]}, 19'h51000);
    go(8'h08, 1'b1);
    go(8'h10, 1'b0);
    chk(sleeping_o, 1'b0);
    go(8'h80, 1'b1);
    wait_ev(10000);
    chk({ev_full, ev_t[15:0]}, 17'h11000);
    $display("test sleep and pin done");
    wdt_enable_i = 1'b0;
    go(8'h20, 1'b0);
    chk(tick_request_flag_o, 1'b0);
    go(8'h01, 1'b0);
    wait_ev(9000);
    chk({seen, tick_request_flag_o}, 2'h1);
    chk({n_full, n_warm}, 16'h0501);
    stack_full_i = 1'b1;
    tick_irq_enable_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk({tick_request_flag_o, tick_call_o}, 2'h2);
    stack_full_i = 1'b0;
    for (i = 0; i < 10 && tick_request_flag_o !== 1'b0; i++) @(negedge sys_clk_i);
    chk({tick_request_flag_o, tick_vector_o}, 9'h014);
    $display("test disable and tick done");
    rtc_control_reg_data_i = 8'h10;
    go(8'h40, 1'b0);
    chk(fast_xtal_startup_bit_o, 1'b1);
    rtc_control_reg_data_i = 8'hEF;
    go(8'h40, 1'b0);
    chk(fast_xtal_startup_bit_o, 1'b0);
    $display("test start-up bit done");
    half_period(1'b0, n);
    chk(n, 8);
    lcd_div_sel_i = 3'h7;
    half_period(1'b0, n);
    chk(n, 256);
    buz_div_sel_i = 3'h7;
    half_period(1'b1, n);
    chk(n, 512);
    buz_div_sel_i = 3'h0;
    half_period(1'b1, n);
    chk(n, 4);
    $display("test clock taps done");
    lcd_div_sel_i = 3'h0;
    src_sel_i = 2'h1;
    half_period(1'b0, n);
    chk(n, 8);
    go(8'h08, 1'b0);
    half_period(1'b0, n);
    chk(n, 0);
    rtc_is_sys_clk_i = 1'b1;
    @(negedge sys_clk_i);
    chk({sleeping_o, sys_osc_run_o}, 2'h3);
    rtc_is_sys_clk_i = 1'b0;
    go(8'h10, 1'b0);
    src_sel_i = 2'h0;
    half_period(1'b0, n);
    chk(n, 0);
    wdt_osc_enable_i = 1'b1;
    half_period(1'b0, n);
    chk(n, 4);
    $display("test clock sources done");
    report_and_stop;
  end
endmodule
